/* File: dv/core_model.sv */
// Purpose: Core sequencer model that paces and uses the call stack.
// Assumes: One instruction every four clocks.
// Notes: Stack requests wait while interrupt entry owns the stack.
`timescale 1ns/1ns
module core_model (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset, active low.
    input wire logic stack_busy, // Entry owns the stack.
    input wire logic pop_valid, // Restored PC valid.
    input wire logic [9:0] pop_pc, // Restored PC.
    output logic second_phase_clock, // Second-phase pulse.
    output logic core_push, // Call push.
    output logic ret_pop // Return pop.
);
    logic [1:0] ph_q;
    logic [9:0] last_pop;
    // Phase counter gives one second-phase pulse per instruction.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ph_q <= 2'h0;
        else
            ph_q <= ph_q + 2'h1;
    end
    assign second_phase_clock = (ph_q == 2'h3);
    // Keeps the last PC handed back by a return.
    always @(posedge pclk) begin
        if (pop_valid === 1'b1)
            last_pop <= pop_pc;
    end
    // Stack requests are idle at start.
    initial begin
        core_push = 1'b0;
        ret_pop = 1'b0;
    end
    // One push or return pop, raised only while the stack is free.
    task automatic stack_op(input logic pop);
        do @(posedge pclk); while (stack_busy !== 1'b0);
        if (pop)
            ret_pop <= 1'b1;
        else
            core_push <= 1'b1;
        @(posedge pclk);
        ret_pop <= 1'b0;
        core_push <= 1'b0;
    endtask
endmodule // core_model

/* File: dv/mcu_interrupt_controller_bench.sv */
// Purpose: Self-checking bench of the interrupt controller.
// Assumes: APB master tasks; the core model paces the second phase.
// Notes: Vector loads are counted over a bounded window.
`timescale 1ns/1ns
module mcu_interrupt_controller_bench import irq_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic second_phase_clock, sleeping, wake_req, vec_load, stack_busy, slv;
    logic core_push, ret_pop, pop_valid, stack_full;
    logic [9:0] next_pc, vec_addr, core_push_pc, pop_pc;
    wire logic timer_ovf0, timer_ovf1, adc_done, tb_event;
    logic [3:0] ev;
    logic shared_port_pin, shared_pin_direction_bit;
    logic pull_high_sel, pull_high_en;
    logic comparator_out, amplifier_zero, amplifier_one;
    int err_total = 0, n_tests = 0, h;
    assign {tb_event, adc_done, timer_ovf1, timer_ovf0} = ev;
    irq_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .second_phase_clock, .sleeping,
        .wake_req, .next_pc, .vec_load, .vec_addr, .stack_busy,
        .core_push, .core_push_pc, .ret_pop, .pop_valid, .pop_pc,
        .stack_full, .timer_ovf0, .timer_ovf1, .adc_done, .tb_event,
        .shared_port_pin, .shared_pin_direction_bit, .pull_high_sel,
        .pull_high_en, .comparator_out, .amplifier_zero, .amplifier_one);
    core_model core_u (.pclk, .presetn, .stack_busy, .pop_valid,
        .pop_pc, .second_phase_clock, .core_push, .ret_pop);
    // Clock of 50 ns period.
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Compares one value and counts the outcome.
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; read data and error taken at the ready edge.
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Counts vector loads over a fixed window of clocks.
    task automatic watch(int cyc);
        h = 0;
        repeat (cyc) begin
            @(posedge pclk);
            if (vec_load === 1'b1)
                h++;
        end
    endtask
    // Pulses the event inputs given by the mask for one clock.
    task automatic pulse(logic [3:0] m);
        ev <= m;
        @(posedge pclk);
        ev <= 4'h0;
        @(posedge pclk);
    endtask
    // Reset values of every register, then an unmapped read.
    task automatic s_reset();
        for (int a = 0; a < 5; a++) begin
            apb(1'b0, ADDR_W'(4 * a), 32'h0);
            chk("reset reg", rd, {24'h0, RST_BYTE});
        end
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped err", {31'h0, slv}, 32'h1);
    endtask
    // Sub-source register keeps only its implemented bits.
    task automatic s_sub();
        apb(1'b1, OFF_SUB, 32'hffffffff);
        apb(1'b0, OFF_SUB, 32'h0);
        chk("sub bits", rd, 32'h77);
    endtask
    // Events latch while globally masked, then one entry serves timer 0.
    task automatic s_latch();
        apb(1'b1, OFF_CTRL0, 32'h04);
        pulse(4'hf);
        watch(24);
        chk("masked loads", h, 0);
        chk("wake", {31'h0, wake_req}, 32'h1);
        apb(1'b0, OFF_CTRL0, 32'h0);
        chk("ctrl0 flags", rd, 32'h64);
        apb(1'b0, OFF_CTL1, 32'h0);
        chk("ctl1 flags", rd, 32'h30);
        sleeping <= 1'b1;
        apb(1'b1, OFF_CTRL0, 32'h25);
        watch(24);
        sleeping <= 1'b0;
        chk("entry loads", h, 1);
        chk("t0 vector", vec_addr, 32'h08);
        apb(1'b0, OFF_CTRL0, 32'h0);
        chk("after entry", rd, 32'h04);
        core_u.stack_op(1'b1);
        repeat (2) @(posedge pclk);
        chk("return pc", core_u.last_pop, next_pc);
    endtask
    // Each edge mode sets the external flag on its own edges only.
    task automatic s_edge();
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, OFF_FIRST, 32'(m << B_EDGE_LO));
            for (int e = 0; e < 2; e++) begin
                apb(1'b1, OFF_CTRL0, 32'h02);
                shared_port_pin <= ~shared_port_pin;
                repeat (4) @(posedge pclk);
                apb(1'b0, OFF_CTRL0, 32'h0);
                chk("ext edge", rd, m[e] ? 32'h12 : 32'h02);
            end
        end
        shared_pin_direction_bit <= 1'b0;
        apb(1'b1, OFF_CTRL0, 32'h02);
        shared_port_pin <= ~shared_port_pin;
        repeat (4) @(posedge pclk);
        apb(1'b0, OFF_CTRL0, 32'h0);
        chk("pin as output", rd, 32'h02);
        chk("pull high", {31'h0, pull_high_en}, 32'h1);
    endtask
    // Comparator and amplifier edges set sub flags and the group flag.
    task automatic s_group();
        apb(1'b1, OFF_CTL1, 32'h0);
        apb(1'b1, OFF_SUB, 32'h07);
        {comparator_out, amplifier_zero, amplifier_one} <= 3'b111;
        repeat (4) @(posedge pclk);
        {amplifier_zero, amplifier_one} <= 2'b00;
        repeat (4) @(posedge pclk);
        apb(1'b0, OFF_SUB, 32'h0);
        chk("sub flags", rd, 32'h77);
        apb(1'b0, OFF_CTL1, 32'h0);
        chk("group flag", rd, 32'h40);
    endtask
    // All six requests pending: served one by one in priority order.
    task automatic s_prio();
        apb(1'b1, OFF_CTL1, 32'h77);
        apb(1'b1, OFF_CTRL0, 32'h7e);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, OFF_CTRL0, 32'h0);
            apb(1'b1, OFF_CTRL0, rd | 32'h1);
            watch(24);
            chk("prio vector", vec_addr, VEC_TABLE[i]);
            core_u.stack_op(1'b1);
        end
    endtask
    // A full stack holds off entry until one return frees a place.
    task automatic s_full();
        repeat (4) core_u.stack_op(1'b0);
        apb(1'b1, OFF_CTRL0, 32'h25);
        chk("full", {31'h0, stack_full}, 32'h1);
        watch(24);
        chk("held loads", h, 0);
        core_u.stack_op(1'b1);
        watch(24);
        chk("freed loads", h, 1);
        repeat (4) core_u.stack_op(1'b1);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Cuts a hang short well after the expected run length.
    initial begin
        #(50 * 20000);
        err_total++;
        complete_run();
    end
    // Reset, then every scenario in turn.
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ev, sleeping} = '0;
        {shared_port_pin, comparator_out, amplifier_zero, amplifier_one} = '0;
        {shared_pin_direction_bit, pull_high_sel} = 2'b11;
        next_pc = 10'h123;
        core_push_pc = 10'h2aa;
        presetn = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s_reset();
        s_sub();
        s_latch();
        s_edge();
        s_group();
        s_prio();
        s_full();
        complete_run();
    end
endmodule // mcu_interrupt_controller_bench

/* File: rtl/flag_bank.sv */
// Purpose: Bank of sticky request flags.
// Assumes: Strobes from the controller, synchronous to pclk.
// Notes: A hardware set beats a software write or a service clear.
`timescale 1ns/1ns
module flag_bank #(
    parameter int unsigned N = 9 // Number of flags.
) (
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    flag_if.bank bus // Strobes in, flags out.
);
    typedef struct packed {
        logic [N-1:0] f;
    } bank_t;

    bank_t q, d;

    // Software write, then service clear, then hardware set on top.
    always_comb begin
        d.f = (bus.we & bus.wval) | (~bus.we & q.f);
        d.f = d.f & ~bus.clr;
        d.f = d.f | bus.set;
    end

    // Flags come up clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bus.q = q.f;

endmodule // flag_bank

/* File: rtl/flag_if.sv */
// Purpose: Set, clear and write strobes of the request flag bank.
// Assumes: All strobes are one-cycle levels on pclk.
// Notes: The controller drives the strobes and reads the flags.
`timescale 1ns/1ns
interface flag_if #(parameter int unsigned N = 9);
    logic [N-1:0] set;
    logic [N-1:0] clr;
    logic [N-1:0] we;
    logic [N-1:0] wval;
    logic [N-1:0] q;
    modport bank (input set, input clr, input we, input wval, output q);
    modport ctl (output set, output clr, output we, output wval, input q);
endinterface

/* File: rtl/irq_ctrl.sv */
// Purpose: Interrupt controller with priority, vectoring and call stack.
// Assumes: Event inputs are one-cycle pulses or levels synchronous to
//   pclk; second_phase_clock pulses once in each instruction.
// Notes: Registers sit on APB with zero wait states.
// Summary of operation
// - Sub-source flags: amplifier one bit 6, zero bit 5, comparator 4.
// - Sub-source enables at bits 2,1,0; bits 7 and 3 read zero.
// - Each hardware event sets its own request flag.
// - On acceptance push next PC, then load the winner's vector.
// - Return from interrupt pops the saved PC to resume.
// - Taking any interrupt clears the global enable.
// - Requests during global disable still latch their flags.
// - No request is acknowledged while the call stack is full.
// - Two instruction cycles to vector, three when waking up.
// - Requests are sampled and serviced on a second-phase pulse.
// - Simultaneous requests resolve by fixed priority, external first.
// - Vectors 04h,08h,0ch,10h,14h,18h in priority order.
// - Global enable clear masks every source.
// - External needs global and pin enable; selected edge sets flag.
// - Edge select 00 off, 01 rising, 10 falling, 11 both.
// - Pull-high on the shared pin stays while it is an interrupt.
// - Serving external clears its flag with the global enable.
// - Timer overflow sets its flag; served with global and own enable.
// - Serving a timer clears that timer's flag.
// - Comparator transition or amplifier fall raises the group request.
// - Group flag set by sub-sources, cleared on service.
// - A set flag stays until served or cleared by software.
// - Global enable is bit 0 of control zero, reset to zero.
// - Every enabled source can wake the core from idle or sleep.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module irq_ctrl import irq_pkg::*; #(
    parameter int unsigned PC_W = 10, // Program counter width.
    parameter int unsigned STACK_DEPTH = 4, // Call stack entries.
    parameter bit TWO_TIMERS = 1'b1 // Second timer present.
) (
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB write.
    input wire logic [ADDR_W-1:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic second_phase_clock, // Second-phase pulse.
    input wire logic sleeping, // Core is in idle or sleep.
    output logic wake_req, // Enabled request pending, wakes the core.
    input wire logic [PC_W-1:0] next_pc, // Address of next instruction.
    output logic vec_load, // Pulse: load vec_addr into the PC.
    output logic [PC_W-1:0] vec_addr, // Vector to load.
    output logic stack_busy, // Stack used by interrupt entry.
    input wire logic core_push, // Call pushes core_push_pc.
    input wire logic [PC_W-1:0] core_push_pc, // Return address of a call.
    input wire logic ret_pop, // Return or return-from-interrupt.
    output logic pop_valid, // Pulse: pop_pc holds the restored PC.
    output logic [PC_W-1:0] pop_pc, // Restored program counter.
    output logic stack_full, // Every stack entry in use.
    input wire logic timer_ovf0, // Timer 0 overflow pulse.
    input wire logic timer_ovf1, // Timer 1 overflow pulse.
    input wire logic adc_done, // Conversion complete pulse.
    input wire logic tb_event, // Time base overflow pulse.
    input wire logic shared_port_pin, // External interrupt pin level.
    input wire logic shared_pin_direction_bit, // 1 when pin is input.
    input wire logic pull_high_sel, // Pull-high chosen for the pin.
    output logic pull_high_en, // Pull-high resistor connected.
    input wire logic comparator_out, // Comparator output level.
    input wire logic amplifier_zero, // Amplifier zero output level.
    input wire logic amplifier_one // Amplifier one output level.
);
    localparam int unsigned SP_W = $clog2(STACK_DEPTH + 1);
    localparam logic [SP_W-1:0] SP_FULL = SP_W'(STACK_DEPTH);
    localparam logic [1:0] CNT_RUN = 2'(LAT_RUN_CYC - 1);
    localparam logic [1:0] CNT_WAKE = 2'(LAT_WAKE_CYC - 1);

    typedef struct packed {
        logic gen_en;
        logic [N_FLAGS-1:0] en;
        ext_edge_t edge_sel;
        logic pin_prev;
        logic cmp_prev;
        logic a0_prev;
        logic a1_prev;
        seq_t seq;
        logic [1:0] cnt;
        logic [2:0] win;
        logic [SP_W-1:0] sp;
        logic [STACK_DEPTH-1:0][PC_W-1:0] stk;
        logic [31:0] rdata;
        logic vec_load;
        logic [PC_W-1:0] vec_addr;
        logic pop_valid;
        logic [PC_W-1:0] pop_pc;
    } state_t;

    state_t q, d;
    flag_if #(.N(N_FLAGS)) fl ();
    logic [N_SRC-1:0] pend;
    logic [N_SRC-1:0] low_mask;
    logic [2:0] win_c;
    logic full, acc, wr_en, hit, pin_act, rise, fall, ext_hit;
    logic cmp_evt, a0_evt, a1_evt;
    logic [7:0] rd_byte;

    flag_bank #(.N(N_FLAGS)) u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .bus(fl)
    );

    // Pin qualification and edge detection on the external input.
    assign pin_act = shared_pin_direction_bit && q.en[SRC_EXT]
        && (q.edge_sel != EDGE_OFF);
    assign rise = shared_port_pin && !q.pin_prev;
    assign fall = !shared_port_pin && q.pin_prev;
    assign ext_hit = pin_act && (
        (q.edge_sel == EDGE_RISE && rise) ||
        (q.edge_sel == EDGE_FALL && fall) ||
        (q.edge_sel == EDGE_BOTH && (rise || fall)));
    assign cmp_evt = comparator_out ^ q.cmp_prev;
    assign a0_evt = q.a0_prev && !amplifier_zero;
    assign a1_evt = q.a1_prev && !amplifier_one;

    // Timer, ADC, time base and sub-source events set their flags whatever the enables say.
    assign fl.set[SRC_EXT] = ext_hit;
    assign fl.set[SRC_T0] = timer_ovf0;
    assign fl.set[SRC_T1] = timer_ovf1 && TWO_TIMERS;
    assign fl.set[SRC_ADC] = adc_done;
    assign fl.set[SRC_TB] = tb_event;
    assign fl.set[SRC_CMP] = cmp_evt;
    assign fl.set[SRC_A0] = a0_evt;
    assign fl.set[SRC_A1] = a1_evt;
    assign fl.set[SRC_GRP] = (cmp_evt && q.en[SRC_CMP])
        || (a0_evt && q.en[SRC_A0])
        || (a1_evt && q.en[SRC_A1]);

    // Pending requests and fixed-priority winner, lowest index first.
    assign pend = fl.q[N_SRC-1:0] & q.en[N_SRC-1:0];
    always_comb begin
        win_c = 3'(N_SRC - 1);
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                win_c = 3'(i);
            end
        end
    end
    assign low_mask = N_SRC'((1 << q.win) - 1);

    assign full = (q.sp == SP_FULL);
    assign acc = second_phase_clock && q.gen_en && (|pend)
        && !full;
    assign wake_req = |pend;
    assign wr_en = psel && penable && pwrite;

    // Read word for the addressed register; reserved bits read zero.
    always_comb begin
        rd_byte = RST_BYTE;
        hit = 1'b1;
        case (paddr)
            OFF_CTRL0: begin
                rd_byte[B_GEN] = q.gen_en;
                rd_byte[B_EXT_EN] = q.en[SRC_EXT];
                rd_byte[B_T0_EN] = q.en[SRC_T0];
                rd_byte[B_T1_EN] = q.en[SRC_T1];
                rd_byte[B_EXT_F] = fl.q[SRC_EXT];
                rd_byte[B_T0_F] = fl.q[SRC_T0];
                rd_byte[B_T1_F] = fl.q[SRC_T1];
            end
            OFF_CTL1: begin
                rd_byte[B_ADC_EN] = q.en[SRC_ADC];
                rd_byte[B_TB_EN] = q.en[SRC_TB];
                rd_byte[B_GRP_EN] = q.en[SRC_GRP];
                rd_byte[B_ADC_F] = fl.q[SRC_ADC];
                rd_byte[B_TB_F] = fl.q[SRC_TB];
                rd_byte[B_GRP_F] = fl.q[SRC_GRP];
            end
            OFF_SUB: begin
                rd_byte[B_CMP_EN] = q.en[SRC_CMP];
                rd_byte[B_A0_EN] = q.en[SRC_A0];
                rd_byte[B_A1_EN] = q.en[SRC_A1];
                rd_byte[B_CMP_F] = fl.q[SRC_CMP];
                rd_byte[B_A0_F] = fl.q[SRC_A0];
                rd_byte[B_A1_F] = fl.q[SRC_A1];
            end
            OFF_FIRST: begin
                rd_byte[B_EDGE_HI:B_EDGE_LO] = q.edge_sel;
            end
            OFF_STAT: begin
                rd_byte[B_ST_FULL] = full;
                rd_byte[B_ST_BUSY] = (q.seq != ST_IDLE);
                rd_byte[ST_SP_LSB +: SP_W] = q.sp;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Next state: register writes, sequencer, then the call stack.
    always_comb begin
        d = q;
        fl.we = '0;
        fl.wval = '0;
        fl.clr = '0;
        d.vec_load = 1'b0;
        d.pop_valid = 1'b0;
        d.pin_prev = shared_port_pin;
        d.cmp_prev = comparator_out;
        d.a0_prev = amplifier_zero;
        d.a1_prev = amplifier_one;
        if (psel && !penable) begin
            d.rdata = {24'h000000, rd_byte};
        end
        if (wr_en) begin
            case (paddr)
                OFF_CTRL0: begin
                    d.gen_en = pwdata[B_GEN];
                    d.en[SRC_EXT] = pwdata[B_EXT_EN];
                    d.en[SRC_T0] = pwdata[B_T0_EN];
                    d.en[SRC_T1] = pwdata[B_T1_EN] && TWO_TIMERS;
                    fl.we[SRC_EXT] = 1'b1;
                    fl.we[SRC_T0] = 1'b1;
                    fl.we[SRC_T1] = 1'b1;
                    fl.wval[SRC_EXT] = pwdata[B_EXT_F];
                    fl.wval[SRC_T0] = pwdata[B_T0_F];
                    fl.wval[SRC_T1] = pwdata[B_T1_F] && TWO_TIMERS;
                end
                OFF_CTL1: begin
                    d.en[SRC_ADC] = pwdata[B_ADC_EN];
                    d.en[SRC_TB] = pwdata[B_TB_EN];
                    d.en[SRC_GRP] = pwdata[B_GRP_EN];
                    fl.we[SRC_ADC] = 1'b1;
                    fl.we[SRC_TB] = 1'b1;
                    fl.we[SRC_GRP] = 1'b1;
                    fl.wval[SRC_ADC] = pwdata[B_ADC_F];
                    fl.wval[SRC_TB] = pwdata[B_TB_F];
                    fl.wval[SRC_GRP] = pwdata[B_GRP_F];
                end
                OFF_SUB: begin
                    d.en[SRC_CMP] = pwdata[B_CMP_EN];
                    d.en[SRC_A0] = pwdata[B_A0_EN];
                    d.en[SRC_A1] = pwdata[B_A1_EN];
                    fl.we[SRC_CMP] = 1'b1;
                    fl.we[SRC_A0] = 1'b1;
                    fl.we[SRC_A1] = 1'b1;
                    fl.wval[SRC_CMP] = pwdata[B_CMP_F];
                    fl.wval[SRC_A0] = pwdata[B_A0_F];
                    fl.wval[SRC_A1] = pwdata[B_A1_F];
                end
                OFF_FIRST: begin
                    d.edge_sel = ext_edge_t'(
                        pwdata[B_EDGE_HI:B_EDGE_LO]);
                end
                default: begin
                end
            endcase
        end
        unique case (q.seq)
            ST_IDLE: begin
                if (acc) begin
                    d.seq = ST_WAIT;
                    d.win = win_c;
                    d.cnt = sleeping ? CNT_WAKE : CNT_RUN;
                end
            end
            ST_WAIT: begin
                if (second_phase_clock) begin
                    d.cnt = q.cnt - 2'd1;
                    if (q.cnt == 2'd1) begin
                        d.seq = ST_JUMP;
                    end
                end
            end
            ST_JUMP: begin
                d.seq = ST_IDLE;
                if (!full) begin
                    d.stk[q.sp] = next_pc;
                    d.sp = q.sp + 1'b1;
                    d.gen_en = 1'b0;
                    fl.clr[q.win] = 1'b1;
                    d.vec_load = 1'b1;
                    d.vec_addr = PC_W'(VEC_TABLE[q.win]);
                end
            end
            default: begin
                d.seq = ST_IDLE;
            end
        endcase
        // The core's own calls and returns use the stack outside entry.
        if (q.seq != ST_JUMP) begin
            if (core_push && !full) begin
                d.stk[q.sp] = core_push_pc;
                d.sp = q.sp + 1'b1;
            end else if (ret_pop && q.sp != '0) begin
                d.sp = q.sp - 1'b1;
                d.pop_pc = q.stk[SP_W'(q.sp - 1'b1)];
                d.pop_valid = 1'b1;
            end
        end
    end

    // All control state clears at reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs from flip-flops, except pready, pslverr and the wake_req, stack_full and stack_busy decodes; the pull-high choice is left untouched.
    assign prdata = q.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign vec_load = q.vec_load;
    assign vec_addr = q.vec_addr;
    assign pop_valid = q.pop_valid;
    assign pop_pc = q.pop_pc;
    assign stack_full = full;
    assign stack_busy = (q.seq == ST_JUMP);
    assign pull_high_en = pull_high_sel;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence svc_s;
        q.seq == ST_JUMP && !full;
    endsequence

    sequence accept_s;
        q.seq == ST_IDLE && second_phase_clock && q.gen_en && (|pend);
    endsequence

    full_blocks_a: assert property (
        (q.seq == ST_IDLE && full) |=> q.seq == ST_IDLE)
        else $error("request accepted with a full stack");
    masked_idle_a: assert property (
        (q.seq == ST_IDLE && !q.gen_en) |=> q.seq == ST_IDLE)
        else $error("request accepted while globally masked");
    phase_sample_a: assert property (
        (q.seq == ST_IDLE && !second_phase_clock) |=> q.seq == ST_IDLE)
        else $error("request accepted off the second phase");
    gen_clear_a: assert property (
        svc_s |=> !q.gen_en && vec_load)
        else $error("global enable not cleared on entry");
    vector_value_a: assert property (
        svc_s |=> vec_addr == PC_W'(VEC_TABLE[$past(q.win)]))
        else $error("wrong vector address");
    pc_pushed_a: assert property (
        svc_s |=> q.sp == $past(q.sp) + 1'b1
            && q.stk[$past(q.sp)] == $past(next_pc))
        else $error("program counter not pushed");
    flag_served_a: assert property (
        (svc_s ##0 !fl.set[q.win]) |=> !fl.q[$past(q.win)])
        else $error("served flag not cleared");
    priority_win_a: assert property (
        accept_s ##0 !full |=> (($past(pend) & low_mask) == '0)
            && (($past(pend) & (low_mask + 1'b1)) != '0))
        else $error("lower priority source won");
    wake_delay_a: assert property (
        (accept_s ##0 !full && sleeping) |=>
            q.seq == ST_WAIT && q.cnt == CNT_WAKE)
        else $error("wake latency not three cycles");
    set_wins_a: assert property (
        (|fl.set) |=> (fl.q & $past(fl.set)) == $past(fl.set))
        else $error("hardware set lost");
    return_from_interrupt_pop_a: assert property (
        (ret_pop && !core_push && q.sp != '0 && q.seq != ST_JUMP) |=>
            pop_valid && pop_pc == $past(q.stk[SP_W'(q.sp - 1'b1)]))
        else $error("return did not restore the saved pc");

endmodule // irq_ctrl

/* File: rtl/irq_pkg.sv */
// Purpose: Shared constants and types of the interrupt controller.
// Assumes: APB byte addresses, 32-bit data, 8-bit registers in low bits.
// Notes: Source index order is also the service priority order.
package irq_pkg;

    // APB register byte addresses.
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CTRL0 = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CTL1 = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_SUB = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_FIRST = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h10;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Interrupt control register zero.
    localparam int unsigned B_GEN = 0;
    localparam int unsigned B_EXT_EN = 1;
    localparam int unsigned B_T0_EN = 2;
    localparam int unsigned B_T1_EN = 3;
    localparam int unsigned B_EXT_F = 4;
    localparam int unsigned B_T0_F = 5;
    localparam int unsigned B_T1_F = 6;
    // Interrupt control register one.
    localparam int unsigned B_ADC_EN = 0;
    localparam int unsigned B_TB_EN = 1;
    localparam int unsigned B_GRP_EN = 2;
    localparam int unsigned B_ADC_F = 4;
    localparam int unsigned B_TB_F = 5;
    localparam int unsigned B_GRP_F = 6;
    // Sub-source control register.
    localparam int unsigned B_CMP_EN = 0;
    localparam int unsigned B_A0_EN = 1;
    localparam int unsigned B_A1_EN = 2;
    localparam int unsigned B_CMP_F = 4;
    localparam int unsigned B_A0_F = 5;
    localparam int unsigned B_A1_F = 6;
    // First control register and status register.
    localparam int unsigned B_EDGE_LO = 6;
    localparam int unsigned B_EDGE_HI = 7;
    localparam int unsigned B_ST_FULL = 0;
    localparam int unsigned B_ST_BUSY = 1;
    localparam int unsigned ST_SP_LSB = 4;

    // Flag indices; the first N_SRC are vectored, lowest index wins.
    localparam int unsigned SRC_EXT = 0;
    localparam int unsigned SRC_T0 = 1;
    localparam int unsigned SRC_T1 = 2;
    localparam int unsigned SRC_ADC = 3;
    localparam int unsigned SRC_TB = 4;
    localparam int unsigned SRC_GRP = 5;
    localparam int unsigned SRC_CMP = 6;
    localparam int unsigned SRC_A0 = 7;
    localparam int unsigned SRC_A1 = 8;
    localparam int unsigned N_SRC = 6;
    localparam int unsigned N_FLAGS = 9;

    // Vector addresses, indexed by source.
    localparam logic [N_SRC-1:0][7:0] VEC_TABLE = {
        8'h18, 8'h14, 8'h10, 8'h0c, 8'h08, 8'h04};

    // Instruction cycles from request to vector, running and waking.
    localparam int unsigned LAT_RUN_CYC = 2;
    localparam int unsigned LAT_WAKE_CYC = 3;

    typedef enum logic [1:0] {
        EDGE_OFF = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } ext_edge_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_JUMP = 2'b11
    } seq_t;

endpackage
